// file: verilog/quad_drv_regs.vh
// Constants for the quad low-side driver control logic
`ifndef QUAD_DRV_REGS_VH
`define QUAD_DRV_REGS_VH

// Serial word layout
`define QD_WORD_BITS      8
`define QD_WORD_MSB       7
`define QD_CHANNELS       4
`define QD_CMD_MSB        3
`define QD_FAULT_MSB      3
`define QD_UPPER_ZERO     4'h0

// Reset values
`define QD_WORD_RESET     8'h00
`define QD_CHAN_RESET     4'h0
`define QD_SYNC_RESET     9'h000
`define QD_SYNC_CS_IDLE   9'h002

// Synchroniser lane positions (index into the synchronised vector)
`define QD_LANE_SCLK      0
`define QD_LANE_CS        1
`define QD_LANE_SI        2
`define QD_LANE_PAR_LSB   3
`define QD_LANE_PAR_MSB   6
`define QD_LANE_OC        7
`define QD_LANE_OL        8
`define QD_SYNC_WIDTH     9

`endif

// file: verilog/bit_sync.v
// Two-flop synchroniser, one lane per bit
`timescale 1ns/10ps
module bit_sync #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  // First stage feeds only the second stage; each lane owns its flops
  // so no vector is written from more than one process
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
      reg stage1;
      reg stage2;

      always @(posedge i_clk) begin
        if (i_rst) begin
          stage1 <= RESET_VAL[g];
          stage2 <= RESET_VAL[g];
        end else begin
          stage1 <= i_async[g];
          stage2 <= stage1;
        end
      end

      assign o_sync[g] = stage2;
    end
  endgenerate

endmodule // bit_sync

// file: verilog/quad_low_side_driver_ctrl.v
// Control and fault reporting for a four-channel low-side driver with serial port
`timescale 1ns/10ps
`include "quad_drv_regs.vh"

module quad_low_side_driver_ctrl (
  input  wire i_clk,
  input  wire i_rst,
  // Serial port pins; the inputs are asynchronous to i_clk, the outputs are registered on it
  input  wire i_chip_select_low,
  input  wire i_sclk,
  input  wire i_si,
  output reg  o_so,
  output reg  o_so_oe,
  // Parallel control pins
  input  wire i_parallel_ctrl_0,
  input  wire i_parallel_ctrl_1,
  input  wire i_parallel_ctrl_2,
  input  wire i_parallel_ctrl_3,
  // Fault comparator levels from the output stages
  input  wire i_overcurrent_0,
  input  wire i_overcurrent_1,
  input  wire i_overcurrent_2,
  input  wire i_overcurrent_3,
  input  wire i_open_load_0,
  input  wire i_open_load_1,
  input  wire i_open_load_2,
  input  wire i_open_load_3,
  // Gate drive for the four low-side switches
  output reg  o_low_side_drive_0,
  output reg  o_low_side_drive_1,
  output reg  o_low_side_drive_2,
  output reg  o_low_side_drive_3,
  // Open-drain fault summary pin
  output wire o_fault_status,
  output reg  o_fault_status_oe
);

  // Gathered views of the per-channel pins
  wire [`QD_CHANNELS-1:0] par_raw;
  wire [`QD_CHANNELS-1:0] oc_raw;
  wire [`QD_CHANNELS-1:0] ol_raw;

  assign par_raw = {i_parallel_ctrl_3, i_parallel_ctrl_2, i_parallel_ctrl_1, i_parallel_ctrl_0};
  assign oc_raw  = {i_overcurrent_3, i_overcurrent_2, i_overcurrent_1, i_overcurrent_0};
  assign ol_raw  = {i_open_load_3, i_open_load_2, i_open_load_1, i_open_load_0};

  // Every pin crosses through two flops; the four fault lanes per kind are
  // synchronised as separate bit_sync instances to keep the lane map small.
  wire [`QD_SYNC_WIDTH-1:0] ctl_async;
  wire [`QD_SYNC_WIDTH-1:0] ctl_sync;
  wire [`QD_CHANNELS-1:0]   oc_sync;
  wire [`QD_CHANNELS-1:0]   ol_sync;

  assign ctl_async = {2'b00, par_raw, i_si, i_chip_select_low, i_sclk};

  // Chip select idles high so reset does not fake a selection
  bit_sync #(
    .WIDTH     (`QD_SYNC_WIDTH),
    .RESET_VAL (`QD_SYNC_CS_IDLE)
  ) u_ctl_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (ctl_async),
    .o_sync  (ctl_sync)
  );

  bit_sync #(
    .WIDTH     (`QD_CHANNELS),
    .RESET_VAL (`QD_CHAN_RESET)
  ) u_oc_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (oc_raw),
    .o_sync  (oc_sync)
  );

  bit_sync #(
    .WIDTH     (`QD_CHANNELS),
    .RESET_VAL (`QD_CHAN_RESET)
  ) u_ol_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (ol_raw),
    .o_sync  (ol_sync)
  );

  wire                    sclk_s;
  wire                    cs_low_s;
  wire                    si_s;
  wire [`QD_CHANNELS-1:0] par_s;

  assign sclk_s   = ctl_sync[`QD_LANE_SCLK];
  assign cs_low_s = ctl_sync[`QD_LANE_CS];
  assign si_s     = ctl_sync[`QD_LANE_SI];
  assign par_s    = ctl_sync[`QD_LANE_PAR_MSB:`QD_LANE_PAR_LSB];

  // Previous samples for edge detection on the synchronised pins
  reg sclk_d;
  reg cs_low_d;

  always @(posedge i_clk) begin
    if (i_rst) begin
      sclk_d   <= 1'b0;
      cs_low_d <= 1'b1;
    end else begin
      sclk_d   <= sclk_s;
      cs_low_d <= cs_low_s;
    end
  end

  wire selected;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;

  // Clock edges only count while selected, so idle clocking is harmless
  assign selected  = ~cs_low_s;
  assign cs_fall   = cs_low_d & ~cs_low_s;
  assign cs_rise   = ~cs_low_d & cs_low_s;
  assign sclk_rise = selected & ~cs_fall & ~sclk_d & sclk_s;
  assign sclk_fall = selected & ~cs_fall & sclk_d & ~sclk_s;

  // Command bits, drive state and fault flags
  reg [`QD_CHANNELS-1:0]  cmd;
  reg [`QD_CHANNELS-1:0]  drive;
  reg [`QD_CHANNELS-1:0]  fault_acc;
  reg [`QD_WORD_MSB:0]    shift_word;
  wire [`QD_CHANNELS-1:0] fault_now;
  wire [`QD_CHANNELS-1:0] next_drive;

  // Fault qualification per channel by the switch state
  genvar ch;
  generate
    for (ch = 0; ch < `QD_CHANNELS; ch = ch + 1) begin : g_chan
      assign fault_now[ch]  = (drive[ch] & oc_sync[ch])
                            | (~drive[ch] & ol_sync[ch]);
      assign next_drive[ch] = cmd[ch] | par_s[ch];
    end
  endgenerate

  // Serial command latched only at the end of a transfer
  always @(posedge i_clk) begin
    if (i_rst) begin
      cmd <= `QD_CHAN_RESET;
    end else if (cs_rise) begin
      cmd <= shift_word[`QD_CMD_MSB:0];
    end
  end

  // Registered drives; parallel inputs act without any transfer
  always @(posedge i_clk) begin
    if (i_rst) begin
      drive <= `QD_CHAN_RESET;
    end else begin
      drive <= next_drive;
    end
  end

  always @* begin
    o_low_side_drive_0 = drive[0];
    o_low_side_drive_1 = drive[1];
    o_low_side_drive_2 = drive[2];
    o_low_side_drive_3 = drive[3];
  end

  // Sticky fault flags, cleared at chip select rise; a fault seen in the
  // clearing cycle survives, but an event that starts and ends inside a frame is dropped unread.
  always @(posedge i_clk) begin
    if (i_rst) begin
      fault_acc <= `QD_CHAN_RESET;
    end else if (cs_rise) begin
      fault_acc <= fault_now;
    end else begin
      fault_acc <= fault_acc | fault_now;
    end
  end

  // Eight-bit shift register; also passes 16-bit words through for
  // command verify, since each bit leaves eight clocks after it entered.
  always @(posedge i_clk) begin
    if (i_rst) begin
      shift_word <= `QD_WORD_RESET;
    end else if (cs_fall) begin
      shift_word <= {`QD_UPPER_ZERO, fault_acc | fault_now};
    end else if (sclk_rise) begin
      shift_word <= {shift_word[`QD_WORD_MSB-1:0], si_s};
    end
  end

  // Serial output: first bit shown at selection, then one per falling clock
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_so <= 1'b0;
    end else if (cs_fall) begin
      o_so <= fault_acc[`QD_FAULT_MSB] & 1'b0; // Bit 7 of the word is zero
    end else if (sclk_fall) begin
      o_so <= shift_word[`QD_WORD_MSB];
    end
  end

  // Serial output floats unless selected
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= selected;
    end
  end

  // Summary pin follows live faults, not the sticky flags
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_status_oe <= 1'b0;
    end else begin
      o_fault_status_oe <= |fault_now;
    end
  end

  // Open drain only ever pulls low
  assign o_fault_status = 1'b0;

endmodule // quad_low_side_driver_ctrl

// file: tb/spi_master_model.sv
// Serial master model for the chip select, clock and data pins
`timescale 1ns/10ps
module spi_master_model (
  input  wire logic so,
  output logic      cs_n = 1'b1,
  output logic      sclk = 1'b0,
  output logic      si   = 1'b0
);
  // Clock rests low between frames; data drops to its pull-down level
  task xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #1000 cs_n = 1'b0;
    // Quarter-ns offset keeps every link edge off the system clock's rising edge
    #200.25;
    for (int i = n - 1; i >= 0; i--) begin
      si = w[i];
      #62.5 sclk = 1'b1;
      rx = {rx[14:0], so};
      #62.5 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    si = 1'b0;
  endtask
endmodule // spi_master_model

// file: tb/quad_low_side_driver_ctrl_sva.sv
// Concurrent checks on the quad low-side driver control ports
`timescale 1ns/10ps
module quad_drv_sva (
  input wire logic i_clk, i_rst, i_chip_select_low, o_so_oe, o_fault_status_oe,
  input wire logic i_parallel_ctrl_0, i_parallel_ctrl_1, i_parallel_ctrl_3, i_overcurrent_2, i_open_load_3,
  input wire logic o_low_side_drive_0, o_low_side_drive_1, o_low_side_drive_2, o_low_side_drive_3
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Pins cross two sync flops and a register, so each check except a_reset_clears waits out that latency
  a_par_drive_0: assert property (i_parallel_ctrl_0 [*5] |-> o_low_side_drive_0)
    else $error("drive 0 ignores its parallel input");
  a_par_drive_3: assert property (i_parallel_ctrl_3 [*5] |-> o_low_side_drive_3)
    else $error("drive 3 ignores its parallel input");
  a_reset_clears: assert property ($fell(i_rst) |-> !o_low_side_drive_0 && !o_so_oe && !o_fault_status_oe)
    else $error("outputs not cleared by reset");
  a_so_off_idle: assert property (i_chip_select_low [*5] |-> !o_so_oe)
    else $error("serial output driven while deselected");
  a_so_on_select: assert property (!i_chip_select_low [*5] |-> o_so_oe)
    else $error("serial output idle while selected");
  a_cmd_hold_idle: assert property ((i_chip_select_low && !i_parallel_ctrl_1) [*6] |-> $stable(o_low_side_drive_1))
    else $error("drive 1 moved without a frame end");
  a_oc_status: assert property ((i_overcurrent_2 && o_low_side_drive_2) [*4] |-> o_fault_status_oe)
    else $error("overcurrent on live drive not flagged");
  a_ol_status: assert property ((i_open_load_3 && !o_low_side_drive_3) [*4] |-> o_fault_status_oe)
    else $error("open load on idle drive not flagged");
endmodule // quad_drv_sva
bind quad_low_side_driver_ctrl quad_drv_sva chk (.*);

// file: tb/quad_low_side_driver_ctrl_tb.sv
// Self-checking bench for the quad low-side driver control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module quad_low_side_driver_ctrl_tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  par = 4'h0, oc = 4'h0, ol = 4'h0;
  logic [15:0] rx;
  wire         cs_n, sclk, si, so, so_oe, st, st_oe, so_pin;
  wire  [3:0]  drv;
  int          mismatches = 0, checked = 0;
  // 250 MHz system clock
  always #2 i_clk = ~i_clk;
  // Undriven serial output shows the inverse, so a late enable spoils the read
  assign so_pin = so_oe ? so : ~so;
  spi_master_model m (.so(so_pin), .cs_n(cs_n), .sclk(sclk), .si(si));
  quad_low_side_driver_ctrl uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_chip_select_low(cs_n), .i_sclk(sclk), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .o_fault_status(st), .o_fault_status_oe(st_oe),
    .i_parallel_ctrl_0(par[0]), .i_parallel_ctrl_1(par[1]), .i_parallel_ctrl_2(par[2]), .i_parallel_ctrl_3(par[3]),
    .i_overcurrent_0(oc[0]), .i_overcurrent_1(oc[1]), .i_overcurrent_2(oc[2]), .i_overcurrent_3(oc[3]),
    .i_open_load_0(ol[0]), .i_open_load_1(ol[1]), .i_open_load_2(ol[2]), .i_open_load_3(ol[3]),
    .o_low_side_drive_0(drv[0]), .o_low_side_drive_1(drv[1]), .o_low_side_drive_2(drv[2]),
    .o_low_side_drive_3(drv[3]));
  // Falling-edge waits keep input changes off the sampling edge
  task w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Short frame, then a long one that echoes its first byte back
  task t_serial;
    `CHK("drives", 4'h0, drv)
    m.xfer(16'h0005, 8, rx);
    w(6);
    `CHK("drives", 4'h5, drv)
    m.xfer(16'hA30A, 16, rx);
    `CHK("faults", 8'h00, rx[15:8])
    `CHK("echo", 8'hA3, rx[7:0])
    w(6);
    `CHK("drives", 4'hA, drv)
  endtask
  // Parallel pins OR into the serial command
  task t_par;
    m.xfer(16'h0001, 8, rx);
    w(1);
    par = 4'h4;
    w(6);
    `CHK("drives", 4'h5, drv)
    par = 4'h8;
    w(6);
    `CHK("drives", 4'h9, drv)
    par = 4'h0;
    m.xfer(16'h0000, 8, rx);
    w(6);
    `CHK("drives", 4'h0, drv)
    par = 4'h1;
    w(6);
    `CHK("drives", 4'h1, drv)
    par = 4'h0;
    w(6);
    `CHK("drives", 4'h0, drv)
  endtask
  // Faults on idle and driven channels, read back by the next frame
  task t_fault;
    ol = 4'h8;
    w(6);
    `CHK("status", 1'b1, st_oe)
    ol = 4'h0;
    oc = 4'h2;
    w(6);
    `CHK("status", 1'b0, st_oe)
    m.xfer(16'h0000, 8, rx);
    `CHK("faults", 8'h08, rx[7:0])
    w(1);
    par = 4'h4;
    w(6);
    ol = 4'h4;
    w(6);
    `CHK("status", 1'b0, st_oe)
    oc = 4'h6;
    w(6);
    `CHK("status", 1'b1, st_oe)
    m.xfer(16'h0000, 8, rx);
    `CHK("faults", 8'h04, rx[7:0])
    `CHK("status pin", 1'b0, st)
  endtask
  initial begin
    w(5);
    i_rst = 1'b0;
    w(1);
    t_serial();
    t_par();
    t_fault();
    end_sim();
  end
  // Watchdog well past the roughly 15 us of frames
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule // quad_low_side_driver_ctrl_tb
